// [hdl/ext_clock_output_pkg.sv]
// Functional notes
// R1: The 25 MHz reference is multiplied by a PLL to a 100 MHz base clock.
// R2: The output clock is the base clock divided by a programmable postscaler.
// R3: Every selectable output frequency has a duty cycle close to fifty percent.
// R4: A four-bit field in control register two bits 11:8 enables and selects output.
// R5: Output and field ignore all resets and power-down modes; only power-on sets them.
// R6: After power-on the output is enabled and runs at 4 MHz.
// R7: Frequency changes are glitch-free; no phase shorter than old or new clock's.
// R8: A new selection takes effect only at a completed output period boundary.
package ext_clock_output_pkg;

    // ------------------------------------------------------------------
    // Clock rates and widths
    // ------------------------------------------------------------------
    localparam int REF_CLOCK_MHZ  = 25;
    localparam int BASE_CLOCK_MHZ = 100;
    localparam int PLL_MULT       = BASE_CLOCK_MHZ / REF_CLOCK_MHZ;
    localparam int SEL_W          = 4;
    localparam int CTRL2_W        = 16;
    localparam int SEL_LSB        = 8;
    localparam int CNT_W          = 7;

    typedef logic [SEL_W-1:0]   sel_type;
    typedef logic [CNT_W-1:0]   cnt_type;
    typedef logic [CTRL2_W-1:0] ctrl2_type;

    // ------------------------------------------------------------------
    // Selection codes and power-on values
    // ------------------------------------------------------------------
    localparam sel_type SEL_OFF   = 4'h0;
    localparam sel_type SEL_RESET = 4'ha;

    // Divide ratio in base clock cycles for each selection code.
    function automatic cnt_type period_of(input sel_type s);
        unique case (s)
            4'h0: period_of = 7'h01;
            4'h1: period_of = 7'h02;
            4'h2: period_of = 7'h03;
            4'h3: period_of = 7'h04;
            4'h4: period_of = 7'h05;
            4'h5: period_of = 7'h08;
            4'h6: period_of = 7'h0a;
            4'h7: period_of = 7'h0c;
            4'h8: period_of = 7'h10;
            4'h9: period_of = 7'h14;
            4'ha: period_of = 7'h19;
            4'hb: period_of = 7'h20;
            4'hc: period_of = 7'h28;
            4'hd: period_of = 7'h32;
            4'he: period_of = 7'h50;
            4'hf: period_of = 7'h64;
        endcase
    endfunction

    // High phase is half the period, rounded up.
    function automatic cnt_type high_of(input sel_type s);
        high_of = CNT_W'((period_of(s) + 7'h01) >> 1);
    endfunction

    function automatic cnt_type low_of(input sel_type s);
        low_of = period_of(s) - high_of(s);
    endfunction

    localparam cnt_type CNT_POR = 7'h18;

endpackage

// [hdl/postscaler_counter.sv]
`timescale 1ns/1ns
module postscaler_counter
    import ext_clock_output_pkg::*;
(
    input  wire logic    clk,
    input  wire logic    por,
    input  wire logic    restart,
    input  wire logic    run,
    input  wire cnt_type period,
    output logic         period_end,
    output cnt_type      cnt_next
);

    cnt_type cnt_reg;

    // ------------------------------------------------------------------
    // Period counter
    // ------------------------------------------------------------------
    assign period_end = run && (cnt_reg == period - 7'h01);                      // R8
    assign cnt_next   = (restart || !run || period_end) ? 7'h00 : cnt_reg + 7'h01; // R2

    // Power-on parks the count on the last cycle so a full high phase follows.
    always_ff @(posedge clk) begin
        if (por) begin
            cnt_reg <= CNT_POR;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

endmodule // postscaler_counter

// [hdl/clock_output_postscaler.sv]
`timescale 1ns/1ns
module clock_output_postscaler
    import ext_clock_output_pkg::*;
(
    input  wire logic      CLK,
    input  wire logic      RST,
    input  wire logic      POR,
    input  wire logic      CTRL2_WR,
    input  wire ctrl2_type CTRL2_WDATA,
    output sel_type        DIVIDER_SELECT,
    output logic           EXT_CLOCK_OUTPUT
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    // CLK is the base clock from the reference multiplier.          // R1
    sel_type sel_reg;
    sel_type pend_reg;
    logic    pend_valid_reg;
    logic    out_reg;

    wire sel_type wr_sel   = CTRL2_WDATA[SEL_LSB +: SEL_W];              // R4
    wire logic    sel_off  = (sel_reg == SEL_OFF);
    wire logic    period_end;
    wire cnt_type cnt_next;
    wire logic    apply    = pend_valid_reg && (period_end || sel_off); // R8
    wire sel_type sel_next = apply ? pend_reg : sel_reg;
    wire logic    run_next = (sel_next != SEL_OFF);                     // R4
    wire logic    out_next = run_next && (cnt_next < high_of(sel_next)); // R3

    postscaler_counter u_counter (
        .clk        (CLK),
        .por        (POR),
        .restart    (apply),
        .run        (!sel_off),
        .period     (period_of(sel_reg)),
        .period_end (period_end),
        .cnt_next   (cnt_next)
    );

    // ------------------------------------------------------------------
    // Selection and output; only power-on touches them, never RST.
    // ------------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (POR) begin
            sel_reg        <= SEL_RESET;                                 // R6
            pend_reg       <= SEL_RESET;
            pend_valid_reg <= 1'b0;
            out_reg        <= 1'b0;
        end else begin
            sel_reg <= sel_next;                                         // R7
            out_reg <= out_next;                                         // R5
            if (CTRL2_WR) begin
                pend_reg       <= wr_sel;
                pend_valid_reg <= 1'b1;
            end else if (apply) begin
                pend_valid_reg <= 1'b0;
            end
        end
    end

    assign DIVIDER_SELECT   = sel_reg;
    assign EXT_CLOCK_OUTPUT = out_reg;

    // ------------------------------------------------------------------
    // Checking helpers
    // ------------------------------------------------------------------
    cnt_type hi_run_reg;
    cnt_type lo_run_reg;
    logic    lo_check_reg;

    always_ff @(posedge CLK) begin
        if (POR) begin
            hi_run_reg   <= 7'h00;
            lo_run_reg   <= 7'h00;
            lo_check_reg <= 1'b0;
        end else begin
            hi_run_reg <= out_reg ? hi_run_reg + 7'h01 : 7'h00;
            lo_run_reg <= out_reg ? 7'h00 : lo_run_reg + 7'h01;
            if (sel_off) begin
                lo_check_reg <= 1'b0;
            end else if (out_reg) begin
                lo_check_reg <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    chk_por_default: assert property (@(posedge CLK) // R6
        POR ##1 !POR |-> sel_reg == SEL_RESET && !out_reg ##1 out_reg)
        else $error("power-on did not start the default clock");

    chk_rst_keeps_state: assert property (@(posedge CLK) disable iff (POR) // R5
        RST && !CTRL2_WR && !pend_valid_reg && !period_end && cnt_next != high_of(sel_reg)
            |=> $stable(sel_reg) && $stable(out_reg))
        else $error("device reset disturbed the clock output");

    chk_write_pends: assert property (@(posedge CLK) disable iff (POR) // R4
        CTRL2_WR |=> pend_valid_reg && pend_reg == $past(CTRL2_WDATA[SEL_LSB +: SEL_W]))
        else $error("written selection was not captured");

    chk_off_is_low: assert property (@(posedge CLK) disable iff (POR) // R4
        sel_off |-> !out_reg)
        else $error("output toggles while disabled");

    chk_high_length: assert property (@(posedge CLK) disable iff (POR) // R3
        $fell(out_reg) |-> hi_run_reg == high_of($past(sel_reg)))
        else $error("high phase length wrong");

    chk_low_length: assert property (@(posedge CLK) disable iff (POR) // R7
        $rose(out_reg) && $past(lo_check_reg) && $past(sel_reg) != SEL_OFF
            |-> lo_run_reg == low_of($past(sel_reg, 2)) || lo_run_reg == low_of($past(sel_reg)))
        else $error("low phase length wrong");

    chk_apply_boundary: assert property (@(posedge CLK) disable iff (POR) // R8
        $changed(sel_reg) |-> $past(period_end) || $past(sel_reg) == SEL_OFF)
        else $error("selection changed inside a period");

    chk_new_period_high: assert property (@(posedge CLK) disable iff (POR) // R8
        $changed(sel_reg) && sel_reg != SEL_OFF |-> out_reg)
        else $error("new frequency did not start with a high phase");

    cov_default_run: cover property (@(posedge CLK) disable iff (POR)
        sel_reg == SEL_RESET && $fell(out_reg));

    cov_switch_freq: cover property (@(posedge CLK) disable iff (POR)
        $changed(sel_reg) && $past(sel_reg) != SEL_OFF && sel_reg != SEL_OFF);

    cov_turn_off: cover property (@(posedge CLK) disable iff (POR)
        $changed(sel_reg) && sel_off);

    cov_rst_running: cover property (@(posedge CLK) disable iff (POR)
        RST && out_reg);

endmodule // clock_output_postscaler

// [testbench/clock_host.sv]
`timescale 1ns/1ns
// ----------------------------------------------------------------------
// Host clocked from the base clock: times each phase of the output in base clock cycles.
// ----------------------------------------------------------------------
module clock_host (
    input  wire logic clk,
    input  wire logic ext_clk,
    output logic      phase_end,
    output logic      phase_level,
    output int        phase_len
);
    int   cnt_reg = 0;
    logic prev_reg = 1'b0;

    always @(posedge clk) begin
        phase_end <= (ext_clk !== prev_reg);
        prev_reg  <= ext_clk;
        if (ext_clk !== prev_reg) begin
            phase_level <= prev_reg;
            phase_len   <= cnt_reg;
            cnt_reg     <= 1;
        end else begin
            cnt_reg <= cnt_reg + 1;
        end
    end
endmodule // clock_host

// [testbench/test_clock_output_postscaler.sv]
`timescale 1ns/1ns
module test_clock_output_postscaler;
    import ext_clock_output_pkg::*;
    logic      CLK, RST, POR, CTRL2_WR, EXT_CLOCK_OUTPUT, ph_end, ph_lvl, last_out;
    ctrl2_type CTRL2_WDATA;
    sel_type   DIVIDER_SELECT, last_sel;
    sel_type   ph_sel [2];
    sel_type   want_q [$];
    int        ph_len, err_count, compares;
    bit        armed = 1'b0;
    logic [31:0] rnd;
    int        div_tab [16] = '{1, 2, 3, 4, 5, 8, 10, 12, 16, 20, 25, 32, 40, 50, 80, 100};

    clock_output_postscaler i_clock_output_postscaler (.CLK(CLK), .RST(RST), .POR(POR), .CTRL2_WR(CTRL2_WR),
        .CTRL2_WDATA(CTRL2_WDATA), .DIVIDER_SELECT(DIVIDER_SELECT), .EXT_CLOCK_OUTPUT(EXT_CLOCK_OUTPUT));
    clock_host i_clock_host (.clk(CLK), .ext_clk(EXT_CLOCK_OUTPUT), .phase_end(ph_end), .phase_level(ph_lvl),
        .phase_len(ph_len));

    // ------------------------------------------------------------------
    // Compare and closing tasks
    // ------------------------------------------------------------------
    task automatic cmp_sel(input string what, input sel_type exp, input sel_type got);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cmp_len(input string what, input int exp, input int got);
        compares++;
        if (got != exp) begin
            err_count++;
            $display("MISMATCH %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    task automatic end_sim();
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // ------------------------------------------------------------------
    // Stimulus tasks
    // ------------------------------------------------------------------
    task automatic write(input sel_type s, input bit last);
        rnd = lfsr(rnd);
        @(posedge CLK);
        CTRL2_WR    <= 1'b1;
        CTRL2_WDATA <= {rnd[15:12], s, rnd[7:0]};
        want_q.push_back(s);
        if (last) begin
            @(posedge CLK);
            CTRL2_WR <= 1'b0;
        end
    endtask

    // Only the last pending selection is expected to take effect.
    task automatic settle();
        sel_type exp;
        exp = want_q[$];
        want_q.delete();
        repeat (205) if (DIVIDER_SELECT !== exp) @(negedge CLK);
        cmp_sel("select", exp, DIVIDER_SELECT);
        repeat (2 * div_tab[exp] + 4) @(posedge CLK);
    endtask

    // ------------------------------------------------------------------
    // Reference model of phase lengths and change points
    // ------------------------------------------------------------------
    always @(negedge CLK) begin
        if (POR) armed = 1'b0;
        if (ph_end) begin
            if (armed && ph_sel[ph_lvl] !== 4'h0) begin
                cmp_len(ph_lvl ? "high_len" : "low_len", ph_lvl ? (div_tab[ph_sel[1]] + 1) / 2 : div_tab[ph_sel[0]] / 2, ph_len);
            end
            armed = armed | !POR;
        end
        if (armed && DIVIDER_SELECT !== last_sel) begin
            cmp_sel("edge_at_change", (DIVIDER_SELECT === 4'h0) ? 4'h0 : 4'h1, {2'b00, last_out, EXT_CLOCK_OUTPUT});
        end
        ph_sel[EXT_CLOCK_OUTPUT] = DIVIDER_SELECT;
        last_sel = DIVIDER_SELECT;
        last_out = EXT_CLOCK_OUTPUT;
    end

    initial begin
        CLK = 1'b0;
        forever #5 CLK = ~CLK;
    end

    initial begin
        repeat (30000) @(posedge CLK);
        err_count++;
        end_sim();
    end

    initial begin
        RST = 1'b1;
        POR = 1'b1;
        CTRL2_WR = 1'b0;
        CTRL2_WDATA = '0;
        rnd = 32'h756fb160;
        err_count = 0;
        compares = 0;
        repeat (6) @(posedge CLK);
        RST <= 1'b0;
        POR <= 1'b0;
        want_q.push_back(SEL_RESET);
        settle();
        for (int k = 0; k < 16; k++) begin
            repeat (rnd[3:0]) @(posedge CLK);
            write(sel_type'(k * 7 + 3), 1'b1);
            settle();
        end
        write(4'h3, 1'b0);
        write(4'h5, 1'b1);
        settle();
        RST <= 1'b1;
        write(4'h6, 1'b1);
        settle();
        RST <= 1'b0;
        POR <= 1'b1;
        repeat (6) @(posedge CLK);
        POR <= 1'b0;
        want_q.push_back(SEL_RESET);
        settle();
        end_sim();
    end
endmodule // test_clock_output_postscaler
